// ==== src/dsk_exec.v ====
`include "dsk_consts.vh"
// Function
// - Opcode 0100_11da decodes decrement_skip_if_nonzero; file value minus one.
// - Destination bit 0 writes working register, 1 writes the file.
// - Nonzero variant skips the next instruction when result is nonzero.
// - Skip discards the prefetched instruction and runs one no-operation cycle per skipped word.
// - One word; one cycle without skip, two with skip over one word.
// - Access bit 0 addresses the access bank, not bank_select_register.
// - Access bit 1 takes the upper address from bank_select_register.
// - Access 0 with extended set: operand up to 95 is indexed offset.
// - Zero variant moves past next instruction when result is zero.
// - Without skip the program_counter advances by 2.
// - Opcode 0010_11da decodes decrement_skip_if_zero; skips on zero.
module dsk_exec (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        instr_valid,
  input  wire [15:0] instr_word,
  input  wire [1:0]  next_instr_words,
  input  wire [20:0] program_counter,
  input  wire [5:0]  bank_select_register,
  input  wire        extended_set_en,
  input  wire [11:0] index_base,
  input  wire [7:0]  file_rdata,
  output wire [1:0]  phase,
  output reg         busy,
  output reg  [11:0] file_addr,
  output reg         file_rd,
  output reg         file_wr,
  output reg  [7:0]  file_wdata,
  output reg         wreg_wr,
  output reg  [7:0]  wreg_wdata,
  output reg         pc_load,
  output reg  [20:0] pc_next,
  output reg         nop_cycle,
  output reg         status_wr
);
  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  wire        cycle_end;
  reg         active;
  reg         is_zero_kind;
  reg         dest_file;
  reg  [7:0]  result;
  reg  [1:0]  skip_nops;
  reg  [20:0] skip_step;
  reg  [1:0]  next_nop_left;
  reg  [20:0] next_pc;
  reg  [1:0]  nop_left;
  reg  [1:0]  skip_words;
  reg  [20:0] base_pc;
  wire [5:0]  op_hi = instr_word[15:10];
  wire        hit_nz = (op_hi == `DSK_OP_NONZERO);
  wire        hit_z  = (op_hi == `DSK_OP_ZERO);
  wire [7:0]  f_off  = instr_word[7:0];
  wire        acc    = instr_word[`DSK_ACC_BIT];
  wire        res_zero = (result == 8'h00);
  wire        do_skip  = is_zero_kind ? res_zero : !res_zero;
  reg  [11:0] next_addr;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  // Any other opcode is left to the rest of the core
  wire        take = instr_valid && (hit_nz || hit_z);

  dsk_phase_counter u_phase (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  // ----------------------------------------
  // Operand address
  // ----------------------------------------
  always @* begin
    if (acc) begin
      // Bank register lends only its low nibble to the 12-bit space
      next_addr = {bank_select_register[3:0], f_off};
    end else if (extended_set_en && f_off <= `DSK_INDEX_LIMIT) begin
      // Indexed window wins over the plain access bank
      next_addr = index_base + {4'h0, f_off};
    end else if (f_off < `DSK_ACCESS_SPLIT) begin
      next_addr = {4'h0, f_off};
    end else begin
      next_addr = {`DSK_ACCESS_HIGH, f_off};
    end
  end

  // ----------------------------------------
  // Execution
  // ----------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active       <= 1'b0;
      busy         <= 1'b0;
      is_zero_kind <= 1'b0;
      dest_file    <= 1'b1;
      result       <= 8'h00;
      nop_left     <= 2'h0;
      skip_words   <= 2'h0;
      base_pc      <= 21'h000000;
      file_addr    <= 12'h000;
      file_rd      <= 1'b0;
      pc_load      <= 1'b0;
      pc_next      <= 21'h000000;
      nop_cycle    <= 1'b0;
    end else begin
      file_rd <= 1'b0;
      pc_load <= 1'b0;
      case (phase)
        `DSK_PH_DECODE: begin
          if (nop_left != 2'h0) begin
            // Fetched words are dropped while flushing
            nop_cycle <= 1'b1;
            nop_left  <= nop_left - 2'h1;
          end else begin
            nop_cycle <= 1'b0;
            if (take) begin
              active       <= 1'b1;
              busy         <= 1'b1;
              is_zero_kind <= hit_z;
              dest_file    <= instr_word[`DSK_DEST_BIT];
              file_addr    <= next_addr;
              base_pc      <= program_counter;
              skip_words   <= next_instr_words;
            end else begin
              busy <= 1'b0;
            end
          end
        end
        `DSK_PH_READ: begin
          if (active) begin
            file_rd <= 1'b1;
          end
        end
        `DSK_PH_COMPUTE: begin
          if (active) begin
            result <= file_rdata - 8'h01;
          end
        end
        default: begin
          if (active) begin
            active   <= 1'b0;
            pc_load  <= 1'b1;
            nop_left <= next_nop_left;
            pc_next  <= next_pc;
            busy     <= do_skip;
          end else if (nop_left == 2'h0) begin
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Destination write-back
  // ----------------------------------------
  // Only one destination strobes per instruction
  wire write_slot = active && (phase == `DSK_PH_WRITE);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      file_wr    <= 1'b0;
      file_wdata <= 8'h00;
      wreg_wr    <= 1'b0;
      wreg_wdata <= 8'h00;
    end else begin
      file_wr <= 1'b0;
      wreg_wr <= 1'b0;
      if (write_slot) begin
        if (dest_file) begin
          file_wr    <= 1'b1;
          file_wdata <= result;
        end else begin
          wreg_wr    <= 1'b1;
          wreg_wdata <= result;
        end
      end
    end
  end

  // ----------------------------------------
  // Skip sizing
  // ----------------------------------------
  // A zero word count from fetch is read as a one-word follower
  always @* begin
    case (skip_words)
      2'h2: begin
        skip_nops = 2'h2;
        skip_step = `DSK_PC_STEP + `DSK_PC_STEP;
      end
      2'h3: begin
        skip_nops = 2'h3;
        skip_step = `DSK_PC_STEP + `DSK_PC_STEP + `DSK_PC_STEP;
      end
      default: begin
        skip_nops = 2'h1;
        skip_step = `DSK_PC_STEP;
      end
    endcase
  end

  // One idle instruction cycle per skipped word
  always @* begin
    if (do_skip) begin
      next_nop_left = skip_nops;
      next_pc       = base_pc + `DSK_PC_STEP + skip_step;
    end else begin
      next_nop_left = 2'h0;
      next_pc       = base_pc + `DSK_PC_STEP;
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // Decrement-and-skip leaves every flag alone
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_wr <= 1'b0;
    end else begin
      status_wr <= 1'b0;
    end
  end
endmodule

// ==== shared/dsk_consts.vh ====
`ifndef DSK_CONSTS_VH
`define DSK_CONSTS_VH
// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define DSK_OP_NONZERO   6'h13
`define DSK_OP_ZERO      6'h0b
`define DSK_DEST_BIT     9
`define DSK_ACC_BIT      8
`define DSK_INDEX_LIMIT  8'h5f
`define DSK_ACCESS_SPLIT 8'h60
`define DSK_ACCESS_HIGH  4'hf
// ----------------------------------------
// Phases and timing
// ----------------------------------------
`define DSK_PH_DECODE    2'h0
`define DSK_PH_READ      2'h1
`define DSK_PH_COMPUTE   2'h2
`define DSK_PH_WRITE     2'h3
`define DSK_PC_STEP      21'h000002
`endif

// ==== src/dsk_phase_counter.v ====
`include "dsk_consts.vh"
module dsk_phase_counter (
  input  wire       ref_clk,
  input  wire       rst,
  output reg  [1:0] phase,
  output wire       cycle_end
);
  assign cycle_end = (phase == `DSK_PH_WRITE);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
endmodule

// ==== verification/dsk_exec_properties.sv ====
module dsk_exec_props (
  input wire        ref_clk,
  input wire        rst,
  input wire [1:0]  phase,
  input wire        file_rd,
  input wire        file_wr,
  input wire        wreg_wr,
  input wire        pc_load,
  input wire        nop_cycle,
  input wire        status_wr,
  input wire [20:0] program_counter,
  input wire [20:0] pc_next
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Timing and effects
  // ----------------------------------------
  property p_rd; file_rd |=> !file_rd; endproperty
  a_rd: assert property (p_rd) else $error("long read");
  property p_st; !status_wr; endproperty
  a_st: assert property (p_st) else $error("status write");
  property p_dst; !(file_wr && wreg_wr); endproperty
  a_dst: assert property (p_dst) else $error("two dests");
  property p_wpc; file_wr || wreg_wr |-> pc_load; endproperty
  a_wpc: assert property (p_wpc) else $error("no pc load");
  property p_lat; file_rd |-> ##2 pc_load; endproperty
  a_lat: assert property (p_lat) else $error("late load");
  property p_ph; phase == 2'h3 |=> phase == 2'h0; endproperty
  a_ph: assert property (p_ph) else $error("phase wrap");
  property p_pc; pc_load |-> (pc_next - program_counter) inside
    {21'h2, 21'h4, 21'h6, 21'h8}; endproperty
  a_pc: assert property (p_pc) else $error("pc step");
  property p_nop; $rose(nop_cycle) |-> nop_cycle [*4]; endproperty
  a_nop: assert property (p_nop) else $error("short no-op");
  c_skip: cover property (pc_load ##1 nop_cycle);
  c_fw: cover property (file_wr);
  c_ww: cover property (wreg_wr);
endmodule

// ==== verification/tb_top.sv ====
`include "dsk_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, instr_valid = 0, extended_set_en = 0;
  logic [15:0] instr_word = 0;
  logic [1:0] next_instr_words = 1;
  logic [20:0] program_counter = 0;
  logic [5:0] bank_select_register = 0;
  logic [11:0] index_base = 0;
  logic [7:0] file_rdata = 0;
  wire [1:0] phase;
  wire busy, file_rd, file_wr, wreg_wr, pc_load, nop_cycle, status_wr;
  wire [11:0] file_addr;
  wire [7:0] file_wdata, wreg_wdata;
  wire [20:0] pc_next;
  int fails = 0, n_checks = 0;
  logic [41:0] q[$], e;
  always #4 ref_clk = ~ref_clk;
  dsk_exec dut_u (.ref_clk, .rst, .instr_valid, .instr_word,
    .next_instr_words, .program_counter, .bank_select_register,
    .extended_set_en, .index_base, .file_rdata, .phase, .busy, .file_addr,
    .file_rd, .file_wr, .file_wdata, .wreg_wr, .wreg_wdata, .pc_load,
    .pc_next, .nop_cycle, .status_wr);
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(posedge ref_clk) if (pc_load === 1'b1) begin
    e = q.pop_front();
    chk(pc_next === e[20:0] && file_addr === e[41:30], "pc/addr");
    chk(e[29] ? file_wr && file_wdata === e[28:21] && !wreg_wr
      : wreg_wr && wreg_wdata === e[28:21] && !file_wr, "dest");
  end
  task automatic run(input [5:0] op, input bit d, a, input [1:0] w,
                     input [7:0] v);
    logic [7:0] f, r;
    logic [5:0] bs;
    logic [20:0] p;
    bit sk, x;
    logic [11:0] ib, ea;
    int n, m;
    f = $urandom;
    bs = $urandom;
    p = {$urandom, 1'b0};
    x = $urandom;
    ib = $urandom;
    ea = a ? {bs[3:0], f} : (x && f <= 8'h5f) ? ib + {4'h0, f}
      : (f < 8'h60 ? {4'h0, f} : {4'hf, f});
    r = v - 8'h01;
    sk = (op == `DSK_OP_ZERO) == (r == 8'h00);
    while (busy !== 1'b0) @(negedge ref_clk);
    @(posedge ref_clk);
    instr_word <= {op, d, a, f};
    file_rdata <= v;
    next_instr_words <= w;
    bank_select_register <= bs;
    program_counter <= p;
    instr_valid <= 1;
    extended_set_en <= x;
    index_base <= ib;
    q.push_back({ea, d, r,
      p + 21'h2 + (sk ? 21'h2 * w : 21'h0)});
    n = 0;
    while (file_rd !== 1'b1 && n++ < 20) @(negedge ref_clk);
    chk(n < 20, "not taken");
    @(posedge ref_clk) instr_valid <= 0;
    n = 0;
    m = 0;
    while (busy !== 1'b0 && m++ < 40) begin
      @(negedge ref_clk);
      n += nop_cycle;
    end
    chk(n == (sk ? 4 * w : 0), "no-op count");
    $display("test done op %h skip %0d", op, sk);
  endtask
  initial begin
    #20us;
    fails++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'h75f04f2d));
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 16; i++)
      run(i[0] ? `DSK_OP_ZERO : `DSK_OP_NONZERO, i[1], i[2], 2'(i % 3 + 1),
          i[3] ? 8'($urandom) : {7'h0, i[1]});
    @(posedge ref_clk);
    instr_word <= 16'h2800;
    instr_valid <= 1;
    repeat (8) @(negedge ref_clk) chk(file_rd === 1'b0, "refused");
    $display("test done refusal");
    wrap_up;
  end
endmodule
bind dsk_exec dsk_exec_props u_props (.ref_clk(ref_clk), .rst(rst),
  .phase(phase), .file_rd(file_rd), .file_wr(file_wr), .wreg_wr(wreg_wr),
  .pc_load(pc_load), .nop_cycle(nop_cycle), .status_wr(status_wr),
  .program_counter(program_counter), .pc_next(pc_next));
